// ---- design/ptr_defines.vh ----
`ifndef PTR_DEFINES_VH
`define PTR_DEFINES_VH
// ---------------------------------------------------------------
// register offsets (byte addresses on wishbone)
// ---------------------------------------------------------------
`define PTR_ADR_W 4
`define PTR_IO_ADDR 4'h3
`define PTR_OFF_STATUS 4'h0
`define PTR_OFF_CMD 4'h0
`define PTR_OFF_DATA 4'h4
`define PTR_OFF_IRQ_STAT 4'h8
`define PTR_OFF_IRQ_MASK 4'hc
// ---------------------------------------------------------------
// status byte bits
// ---------------------------------------------------------------
`define PTR_ST_OVERRUN 0
`define PTR_ST_STOPPED 3
`define PTR_ST_PENDING 4
`define PTR_ST_ATTN 5
`define PTR_ST_UNAVAIL 7
// ---------------------------------------------------------------
// command byte bits
// ---------------------------------------------------------------
`define PTR_CMD_IRQ_OFF 0
`define PTR_CMD_IRQ_ON 1
`define PTR_CMD_STOP 2
`define PTR_CMD_RUN 3
`define PTR_CMD_STEP 4
`define PTR_CMD_FAST 5
`define PTR_CMD_BACK 6
`define PTR_CMD_AHEAD 7
// ---------------------------------------------------------------
// interrupt status bits
// ---------------------------------------------------------------
`define PTR_IRQ_PENDING 0
`define PTR_IRQ_ATTN 1
`define PTR_IRQ_W 2
`define PTR_MODE_STEP 1'b0
`define PTR_MODE_FAST 1'b1
`define PTR_BYTE_ZERO 8'h00
`endif

// ---- design/ptr_sync.v ----
`timescale 1ns/100ps
// two-flop synchroniser, one per bit
module ptr_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // data
    input wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk_sys) begin
                if (!rst_n) begin
                    meta_ff[i] <= 1'b0;
                    sync_ff[i] <= 1'b0;
                end else begin
                    meta_ff[i] <= din[i];
                    sync_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate
    assign dout = sync_ff;
endmodule

// ---- design/ptr_ctrl.v ----
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "ptr_defines.vh"
// Summary of operation
// - status read, command write at address 03; here both sit at Wishbone offset 0
// - overrun when next char beats request
// - stopped flag while tape not moving
// - pending while buffered char unrequested
// - attention is overrun or stopped
// - unavailable when power off or load
// - bit0 disables, bit1 enables interrupt
// - bit2 halts tape motion
// - bit3 starts tape motion
// - bit4 step mode, advance per char
// - bit5 fast-run until stop pattern sensed
// - bit6 backward travel, bidirectional readers only
// - bit7 forward travel
module ptr_ctrl (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`PTR_ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    output wire wb_err_o,
    // reader mechanism (asynchronous pins)
    input wire rdr_power_ok,
    input wire rdr_load_pos,
    input wire rdr_moving,
    input wire rdr_char_strobe,
    input wire [7:0] rdr_char,
    input wire rdr_stop_seen,
    input wire rdr_bidir,
    output reg rdr_motor_ff,
    output reg rdr_backward_ff,
    output reg rdr_fast_ff,
    output reg rdr_step_ff,
    // interrupt
    output wire irq
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    wire [5:0] pins_s;
    ptr_sync #(.W(6)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .din({rdr_power_ok, rdr_load_pos, rdr_moving, rdr_char_strobe,
              rdr_stop_seen, rdr_bidir}),
        .dout(pins_s)
    );
    wire power_ok_s = pins_s[5];
    wire load_pos_s = pins_s[4];
    wire moving_s = pins_s[3];
    wire strobe_s = pins_s[2];
    wire stop_seen_s = pins_s[1];
    wire bidir_s = pins_s[0];
    // char data is stable around the strobe; sampled on the strobe edge
    reg strobe_d_ff;
    wire char_evt = strobe_s & ~strobe_d_ff;
    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    reg ack_ff;
    reg err_ff;
    wire req = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
    wire sel_lo = wb_sel_i[0];
    wire hit_stat = wb_adr_i == `PTR_OFF_STATUS;
    wire hit_data = wb_adr_i == `PTR_OFF_DATA;
    wire hit_istat = wb_adr_i == `PTR_OFF_IRQ_STAT;
    wire hit_imask = wb_adr_i == `PTR_OFF_IRQ_MASK;
    wire mapped = hit_stat | hit_data | hit_istat | hit_imask;
    wire cmd_wr = req & wb_we_i & hit_stat & sel_lo;
    wire [7:0] cmd = wb_dat_i[7:0];
    wire data_rd = req & ~wb_we_i & hit_data; // reading data is the char request
    wire istat_wr = req & wb_we_i & hit_istat & sel_lo;
    wire imask_wr = req & wb_we_i & hit_imask & sel_lo;
    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg [7:0] buf_ff;
    reg pending_ff;
    reg overrun_ff;
    reg irq_en_ff;
    reg [`PTR_IRQ_W-1:0] istat_ff;
    reg [`PTR_IRQ_W-1:0] imask_ff;
    reg mode_ff;
    reg step_req_ff;
    wire stopped = ~moving_s;
    wire attn = overrun_ff | stopped;
    wire unavail = ~power_ok_s | load_pos_s;
    wire [7:0] status_byte = {unavail, 1'b0, attn, pending_ff, stopped,
                              2'b00, overrun_ff};
    reg pending_d_ff;
    reg attn_d_ff;
    wire [`PTR_IRQ_W-1:0] ev = {attn & ~attn_d_ff, pending_ff & ~pending_d_ff};
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            strobe_d_ff <= 1'b0;
            buf_ff <= `PTR_BYTE_ZERO;
            pending_ff <= 1'b0;
            overrun_ff <= 1'b0;
            irq_en_ff <= 1'b0;
            istat_ff <= {`PTR_IRQ_W{1'b0}};
            imask_ff <= {`PTR_IRQ_W{1'b0}};
            mode_ff <= `PTR_MODE_STEP;
            step_req_ff <= 1'b0;
            pending_d_ff <= 1'b0;
            attn_d_ff <= 1'b0;
            rdr_motor_ff <= 1'b0;
            rdr_backward_ff <= 1'b0;
            rdr_fast_ff <= 1'b0;
            rdr_step_ff <= 1'b0;
        end else begin
            ack_ff <= req & mapped;
            err_ff <= req & ~mapped;
            strobe_d_ff <= strobe_s;
            pending_d_ff <= pending_ff;
            attn_d_ff <= attn;
            if (req & ~wb_we_i) begin
                wb_dat_o <= 32'h0000_0000;
                if (hit_stat)
                    wb_dat_o[7:0] <= status_byte;
                else if (hit_data)
                    wb_dat_o[7:0] <= buf_ff;
                else if (hit_istat)
                    wb_dat_o[`PTR_IRQ_W-1:0] <= istat_ff;
                else if (hit_imask)
                    wb_dat_o[`PTR_IRQ_W-1:0] <= imask_ff;
            end
            // a new char wins over a request in the same cycle
            if (char_evt) begin
                buf_ff <= rdr_char;
                pending_ff <= 1'b1;
                if (pending_ff & ~data_rd)
                    overrun_ff <= 1'b1;
            end else if (data_rd) begin
                pending_ff <= 1'b0;
            end
            // overrun cleared by a fresh run command
            if (cmd_wr & cmd[`PTR_CMD_RUN] & ~(char_evt & pending_ff & ~data_rd))
                overrun_ff <= 1'b0;
            // step mode: one advance per char handed over
            rdr_step_ff <= 1'b0;
            if (data_rd & mode_ff == `PTR_MODE_STEP & rdr_motor_ff)
                step_req_ff <= 1'b1;
            if (step_req_ff) begin
                rdr_step_ff <= 1'b1;
                step_req_ff <= 1'b0;
            end
            if (rdr_fast_ff & stop_seen_s)
                rdr_motor_ff <= 1'b0;
            if (cmd_wr) begin
                // enable wins if both bits are written
                if (cmd[`PTR_CMD_IRQ_OFF])
                    irq_en_ff <= 1'b0;
                if (cmd[`PTR_CMD_IRQ_ON])
                    irq_en_ff <= 1'b1;
                if (cmd[`PTR_CMD_STEP])
                    mode_ff <= `PTR_MODE_STEP;
                if (cmd[`PTR_CMD_FAST])
                    mode_ff <= `PTR_MODE_FAST;
                if (cmd[`PTR_CMD_BACK] & bidir_s)
                    rdr_backward_ff <= 1'b1;
                if (cmd[`PTR_CMD_AHEAD])
                    rdr_backward_ff <= 1'b0;
                if (cmd[`PTR_CMD_RUN])
                    rdr_motor_ff <= 1'b1;
                if (cmd[`PTR_CMD_STOP])
                    rdr_motor_ff <= 1'b0;
            end
            rdr_fast_ff <= (cmd_wr & cmd[`PTR_CMD_FAST]) ? 1'b1 :
                           (cmd_wr & cmd[`PTR_CMD_STEP]) ? 1'b0 : mode_ff;
            // sticky events: set beats write-one-to-clear
            istat_ff <= (istat_ff & ~(istat_wr ? wb_dat_i[`PTR_IRQ_W-1:0] :
                        {`PTR_IRQ_W{1'b0}})) | ev;
            if (imask_wr)
                imask_ff <= wb_dat_i[`PTR_IRQ_W-1:0];
        end
    end
    // level output; disabling holds events until re-enabled
    assign irq = irq_en_ff & |(istat_ff & imask_ff);
endmodule

// ---- dv/ptr_ctrl_sva.sv ----
`timescale 1ns/100ps
module ptr_ctrl_sva (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // reader and interrupt
    input wire logic rdr_bidir,
    input wire logic rdr_motor_ff,
    input wire logic rdr_backward_ff,
    input wire logic rdr_fast_ff,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_cmd;
        s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h0);
    endsequence
    a_ack_next: assert property (s_take |=> (wb_ack_o || wb_err_o) ##1 !wb_ack_o)
        else $error("bus answer late or long");
    a_err_unmapped: assert property (s_take ##0 wb_adr_i[1:0] != 2'b00 |=> wb_err_o)
        else $error("unmapped access not refused");
    a_attn_or: assert property (s_take ##0 !wb_we_i && wb_adr_i == 4'h0
        |=> wb_dat_o[5] == (wb_dat_o[0] || wb_dat_o[3])) else $error("attention wrong");
    a_irq_off: assert property (s_cmd ##0 wb_dat_i[0] && !wb_dat_i[1] |=> !irq)
        else $error("interrupt not disabled");
    a_stop_cmd: assert property (s_cmd ##0 wb_dat_i[2] |=> !rdr_motor_ff)
        else $error("motor not halted");
    a_run_cmd: assert property (s_cmd ##0 wb_dat_i[3] && !wb_dat_i[2] |=> rdr_motor_ff)
        else $error("motor not started");
    a_mode_sel: assert property (s_cmd ##0 wb_dat_i[4] != wb_dat_i[5]
        |=> rdr_fast_ff == $past(wb_dat_i[5])) else $error("mode not taken");
    a_back_dir: assert property (s_cmd ##0 wb_dat_i[6] && !wb_dat_i[7] && rdr_bidir
        && $past(rdr_bidir, 3) |=> rdr_backward_ff) else $error("reverse not taken");
endmodule
bind ptr_ctrl ptr_ctrl_sva u_sva (.*);

// ---- dv/ptr_rdr_model.sv ----
`timescale 1ns/100ps
module ptr_rdr_model #(
    parameter PER = 12,
    parameter STOP_CHR = 8'h03
) (
    // controller side
    input wire logic clk_sys,
    input wire logic motor,
    input wire logic fast,
    input wire logic step,
    // reader pins
    output logic moving = 1'b0,
    output logic strobe = 1'b0,
    output logic [7:0] chr = 8'h00,
    output logic stop_seen = 1'b0
);
    int cnt = 0;
    int age = 0;
    logic [7:0] val = 8'h00;
    wire go = (motor && fast && cnt == PER - 1) || step;
    always @(posedge clk_sys) begin
        moving <= motor;
        cnt <= (motor && fast && cnt < PER - 1) ? cnt + 1 : 0;
        strobe <= go;
        stop_seen <= motor && fast && val == STOP_CHR;
        age <= go ? 0 : age + 1;
        if (go) begin
            val <= val + 8'h01;
            chr <= val + 8'h01;
        end else if (age == 5) begin
            // hold span over: stale data must not look valid
            chr <= ~chr;
        end
    end
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/100ps
module tb;
    logic clk_sys = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic pwr = 1'b1, load = 1'b0, bidir = 1'b1, e;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, q;
    logic ack, err, moving, strobe, stop_seen, motor, back, fast, step, irq;
    logic [7:0] chr;
    int fail_count = 0;
    int comparisons = 0;
    typedef struct {logic [3:0] a; logic w; logic [31:0] d; logic [31:0] x; logic er;} ptr_row_t;
    ptr_row_t rows [5] = '{'{4'h0, 1'b0, 32'h0000_0000, 32'h0000_0028, 1'b0},
        '{4'hc, 1'b1, 32'h0000_0003, 32'h0000_0000, 1'b0},
        '{4'hc, 1'b0, 32'h0000_0000, 32'h0000_0003, 1'b0},
        '{4'h1, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1},
        '{4'h0, 1'b1, 32'h0000_0002, 32'h0000_0000, 1'b0}};
    ptr_ctrl u_ptr_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(err), .rdr_power_ok(pwr), .rdr_load_pos(load),
        .rdr_moving(moving), .rdr_char_strobe(strobe), .rdr_char(chr),
        .rdr_stop_seen(stop_seen), .rdr_bidir(bidir), .rdr_motor_ff(motor),
        .rdr_backward_ff(back), .rdr_fast_ff(fast), .rdr_step_ff(step), .irq(irq));
    ptr_rdr_model u_ptr_rdr_model (.clk_sys(clk_sys), .motor(motor), .fast(fast),
        .step(step), .moving(moving), .strobe(strobe), .chr(chr), .stop_seen(stop_seen));
    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // answer sampled before this edge's updates land
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_sys);
        {cyc, stb, we, adr, dat_i} <= {2'b11, w, a, d};
        repeat (50) begin
            @(posedge clk_sys);
            if (ack === 1'b1 || err === 1'b1) break;
        end
        // no answer at all counts as a mismatch
        if (ack !== 1'b1 && err !== 1'b1) fail_count++;
        q = dat_o;
        e = err;
        {cyc, stb} <= 2'b00;
    endtask
    task stop_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial forever #5 clk_sys = ~clk_sys;
    initial begin
        #20000;
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        // synced pin view is zero for two edges after release
        repeat (3) @(posedge clk_sys);
        foreach (rows[i]) begin
            wb(rows[i].a, rows[i].w, rows[i].d);
            chk("bus err", 32'(e), 32'(rows[i].er));
            if (!rows[i].w && !rows[i].er) chk("read", q, rows[i].x);
        end
        wb(4'h0, 1'b1, 32'h0000_0028);
        repeat (80) @(posedge clk_sys);
        chk("motor", 32'(motor), 32'h0000_0000);
        wb(4'h0, 1'b0, 32'h0000_0000);
        chk("status", q, 32'h0000_0039);
        chk("irq", 32'(irq), 32'h0000_0001);
        wb(4'h0, 1'b1, 32'h0000_0001);
        chk("irq", 32'(irq), 32'h0000_0000);
        wb(4'h8, 1'b1, 32'h0000_0003);
        wb(4'h0, 1'b1, 32'h0000_0002);
        chk("irq", 32'(irq), 32'h0000_0000);
        wb(4'h0, 1'b1, 32'h0000_0018);
        wb(4'h4, 1'b0, 32'h0000_0000);
        repeat (10) @(posedge clk_sys);
        wb(4'h0, 1'b0, 32'h0000_0000);
        chk("status", q, 32'h0000_0010);
        chk("irq", 32'(irq), 32'h0000_0001);
        wb(4'h4, 1'b0, 32'h0000_0000);
        chk("char", q, 32'h0000_0004);
        wb(4'h0, 1'b1, 32'h0000_0004);
        chk("motor", 32'(motor), 32'h0000_0000);
        repeat (8) @(posedge clk_sys);
        wb(4'h0, 1'b0, 32'h0000_0000);
        chk("stopped", q & 32'h0000_0008, 32'h0000_0008);
        wb(4'h0, 1'b1, 32'h0000_0040);
        chk("reverse", 32'(back), 32'h0000_0001);
        wb(4'h0, 1'b1, 32'h0000_0080);
        chk("reverse", 32'(back), 32'h0000_0000);
        bidir <= 1'b0;
        pwr <= 1'b0;
        repeat (6) @(posedge clk_sys);
        wb(4'h0, 1'b1, 32'h0000_0040);
        chk("reverse", 32'(back), 32'h0000_0000);
        wb(4'h0, 1'b0, 32'h0000_0000);
        chk("unavail", q & 32'h0000_0080, 32'h0000_0080);
        pwr <= 1'b1;
        load <= 1'b1;
        repeat (6) @(posedge clk_sys);
        wb(4'h0, 1'b0, 32'h0000_0000);
        chk("unavail", q & 32'h0000_0080, 32'h0000_0080);
        stop_test();
    end
endmodule
